// ==== dcpw_consts.vh ====
// constants for the two-channel phy command and write-data port
// assumes inclusion by bare name from every design file of the block
`ifndef DCPW_CONSTS_VH
`define DCPW_CONSTS_VH

// bits carried per dram pin: four dram clocks, two bits each
`define DCPW_BITS_PER_PIN 8
`define DCPW_SLOTS        4
`define DCPW_SLOT_W       2

// pin counts per channel; logical rank pins for the one shared bus
`define DCPW_CKE_PINS     2
`define DCPW_CS_PINS      2
`define DCPW_ODT_PINS     2
`define DCPW_LR_PINS      1

// write data lanes over both channels
`define DCPW_DQ_LANES     32
`define DCPW_DM_LANES     4

// port widths in bits, per channel unless noted
`define DCPW_CKE_CH       (`DCPW_CKE_PINS * `DCPW_BITS_PER_PIN)
`define DCPW_CS_CH        (`DCPW_CS_PINS * `DCPW_BITS_PER_PIN)
`define DCPW_ODT_CH       (`DCPW_ODT_PINS * `DCPW_BITS_PER_PIN)
`define DCPW_LR_BUS       (`DCPW_LR_PINS * `DCPW_BITS_PER_PIN)
`define DCPW_DQ_CH        (`DCPW_DQ_LANES * `DCPW_BITS_PER_PIN / 2)
`define DCPW_DM_CH        (`DCPW_DM_LANES * `DCPW_BITS_PER_PIN / 2)

// buffer tag and write latency widths
`define DCPW_TAG_W        5
`define DCPW_LAT_W        6
`define DCPW_LAT_RST      6'h00

// request delay pipeline: depth and delay field of the latency
`define DCPW_PIPE_DEPTH   16
`define DCPW_DLY_W        4
`define DCPW_DLY_LSB      2
`define DCPW_DLY_MSB      5
`define DCPW_CNT_W        5

// memory types
`define DCPW_MEM_DDR3     1'b0
`define DCPW_MEM_DDR4     1'b1

// mask settings
`define DCPW_DM_NONE      2'h0
`define DCPW_DM_MASK      2'h1
`define DCPW_DM_MASK_RDINV 2'h2
`define DCPW_DM_DBI_ONLY  2'h3

`endif

// ==== dcpw_wr_pipe.v ====
// request delay line of one channel: holds the tag of each write
// assumes delay_i is stable while writes are in flight
`timescale 1ns/1ps
`default_nettype none
`include "dcpw_consts.vh"

module dcpw_wr_pipe (
  // clock and reset
  input  wire                       clk_i,
  input  wire                       rst_b_i,
  // control
  input  wire                       flush_i,
  input  wire [`DCPW_DLY_W-1:0]     delay_i,
  // write command in
  input  wire                       push_i,
  input  wire [`DCPW_TAG_W-1:0]     tag_i,
  // request out
  output reg                        req_o,
  output reg  [`DCPW_TAG_W-1:0]     tag_o
);

  reg  [`DCPW_PIPE_DEPTH-1:0]             vld_ff;
  reg  [`DCPW_PIPE_DEPTH*`DCPW_TAG_W-1:0] tag_ff;
  wire [`DCPW_DLY_W-1:0]                  tap_idx;

  // zero delay is treated as one stage
  assign tap_idx = (delay_i == 4'h0) ? 4'h0 : (delay_i - 4'h1);

  // shift valid and tag one stage every cycle; a flush clears valid and holds tag
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vld_ff <= {`DCPW_PIPE_DEPTH{1'b0}};
      tag_ff <= {(`DCPW_PIPE_DEPTH*`DCPW_TAG_W){1'b0}};
    end else if (flush_i) begin
      vld_ff <= {`DCPW_PIPE_DEPTH{1'b0}};
    end else begin
      vld_ff <= {vld_ff[`DCPW_PIPE_DEPTH-2:0], push_i};
      tag_ff <= {tag_ff[(`DCPW_PIPE_DEPTH-1)*`DCPW_TAG_W-1:0], tag_i};
    end
  end

  // registered tap: one pulse and its stored tag per write
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_o <= 1'b0;
      tag_o <= {`DCPW_TAG_W{1'b0}};
    end else begin
      req_o <= vld_ff[tap_idx] & ~flush_i;
      tag_o <= tag_ff[tap_idx*`DCPW_TAG_W +: `DCPW_TAG_W];
    end
  end

endmodule
`default_nettype wire

// ==== dcpw_wr_capture.v ====
// write data capture of one channel, one cycle after its request
// assumes the controller drives data in the cycle after the request
`timescale 1ns/1ps
`default_nettype none
`include "dcpw_consts.vh"

module dcpw_wr_capture #(
  parameter DW = 128,
  parameter MW = 16
) (
  // clock and reset
  input  wire          clk_i,
  input  wire          rst_b_i,
  // request seen on the port, and mask presence
  input  wire          req_i,
  input  wire          mask_en_i,
  // write data from the controller
  input  wire [DW-1:0] data_i,
  input  wire [MW-1:0] mask_i,
  // captured burst
  output reg  [DW-1:0] data_o,
  output reg  [MW-1:0] mask_o,
  output reg           valid_o
);

  reg req_d_ff;

  // take data and mask together one cycle after the request
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_d_ff <= 1'b0;
      valid_o  <= 1'b0;
      data_o   <= {DW{1'b0}};
      mask_o   <= {MW{1'b0}};
    end else begin
      req_d_ff <= req_i;
      valid_o  <= req_d_ff;
      if (req_d_ff) begin
        data_o <= data_i;
        mask_o <= mask_en_i ? mask_i : {MW{1'b0}};
      end
    end
  end

endmodule
`default_nettype wire

// ==== dcpw_top.v ====
// two-channel phy port: rank control commands and write data path
// assumes one system clock for phy and controller, inputs synchronous
`timescale 1ns/1ps
`default_nettype none
`include "dcpw_consts.vh"

// Overview of operation
// - clock enable is eight bits per pin; shared option halves bus
// - clock enable low half feeds channel 0, upper half channel 1; shared, one field feeds both
// - clock enable order: ch1 rank1, ch1 rank0, ch0 rank1, ch0 rank0
// - chip select is active low, eight bits per pin, split by halves
// - chip select order: ch1 rank1, ch1 rank0, ch0 rank1, ch0 rank0
// - termination is active high, eight bits per pin, split by halves
// - termination order: ch1 rank1, ch1 rank0, ch0 rank1, ch0 rank0
// - logical rank select uses the same eight bits per pin format
// - write data is eight bits per lane: a whole burst per cycle
// - write data low half is channel 0, upper half channel 1
// - mask exists for ddr3 masking, ddr4 mask or mask with read inv
// - write mask low half is channel 0, upper half channel 1
// - one request pulse per write command taken in run, unless calibration drops first; bit 0 ch0, bit 1 ch1
// - upper returned tag field is channel 1, lower is channel 0
// - six bit output shows the write latency in use
// - each byte is four dram clocks, first clock in lowest two bits
module dcpw_top #(
  parameter CKE_SHARED = 0,
  parameter MEM_TYPE   = `DCPW_MEM_DDR4,
  parameter DM_MODE    = `DCPW_DM_MASK
) (
  // clock and reset
  input  wire                        clk_i,
  input  wire                        rst_b_i,
  // calibration status
  input  wire                        calibration_complete_i,
  // rank control commands
  input  wire [(CKE_SHARED?1:2)*`DCPW_CKE_CH-1:0] cmd_clock_enable_in_i,
  input  wire [2*`DCPW_CS_CH-1:0]    cmd_chip_select_in_b_i,
  input  wire [2*`DCPW_ODT_CH-1:0]   cmd_termination_in_i,
  input  wire [`DCPW_LR_BUS-1:0]     cmd_logical_rank_in_i,
  // write commands and latency setting
  input  wire [1:0]                  wr_cmd_i,
  input  wire [2*`DCPW_TAG_W-1:0]    wr_cmd_tag_i,
  input  wire [`DCPW_LAT_W-1:0]      write_latency_cfg_i,
  // write data from the controller
  input  wire [2*`DCPW_DQ_CH-1:0]    write_payload_in_i,
  input  wire [2*`DCPW_DM_CH-1:0]    write_byte_mask_in_i,
  input  wire [2*`DCPW_TAG_W-1:0]    reserved_buffer_tag_in_i,
  // per channel rank control out
  output reg  [`DCPW_CKE_CH-1:0]     ch0_cke_o,
  output reg  [`DCPW_CKE_CH-1:0]     ch1_cke_o,
  output reg  [`DCPW_CS_CH-1:0]      ch0_cs_b_o,
  output reg  [`DCPW_CS_CH-1:0]      ch1_cs_b_o,
  output reg  [`DCPW_ODT_CH-1:0]     ch0_odt_o,
  output reg  [`DCPW_ODT_CH-1:0]     ch1_odt_o,
  output reg  [`DCPW_LR_BUS-1:0]     logical_rank_o,
  output reg  [2*`DCPW_SLOTS-1:0]    cmd_slots_o,
  // write request port
  output wire [1:0]                  write_payload_request_o,
  output wire [2*`DCPW_TAG_W-1:0]    write_buffer_tag_out_o,
  output reg  [`DCPW_LAT_W-1:0]      write_latency_out_o,
  output reg  [1:0]                  wr_pending_o,
  output reg                         reserved_tag_fault_o,
  // captured write bursts per channel
  output wire [`DCPW_DQ_CH-1:0]      ch0_wdata_o,
  output wire [`DCPW_DQ_CH-1:0]      ch1_wdata_o,
  output wire [`DCPW_DM_CH-1:0]      ch0_wmask_o,
  output wire [`DCPW_DM_CH-1:0]      ch1_wmask_o,
  output wire [1:0]                  wdata_valid_o
);

  // ------------------------------------------------------------------
  // bus widths
  // ------------------------------------------------------------------
  localparam CKE_CH  = `DCPW_CKE_PINS * `DCPW_BITS_PER_PIN;
  localparam CKE_BUS = (CKE_SHARED != 0) ? CKE_CH : 2 * CKE_CH;
  localparam CS_CH   = `DCPW_CS_PINS * `DCPW_BITS_PER_PIN;
  localparam CS_BUS  = 2 * CS_CH;
  localparam ODT_CH  = `DCPW_ODT_PINS * `DCPW_BITS_PER_PIN;
  localparam ODT_BUS = 2 * ODT_CH;
  localparam LR_BUS  = `DCPW_LR_PINS * `DCPW_BITS_PER_PIN;
  localparam DQ_BUS  = `DCPW_DQ_LANES * `DCPW_BITS_PER_PIN;
  localparam DQ_CH   = DQ_BUS / 2;
  localparam DM_BUS  = `DCPW_DM_LANES * `DCPW_BITS_PER_PIN;
  localparam DM_CH   = DM_BUS / 2;

  // one-hot states of the port
  localparam ST_WAIT = 2'b01;
  localparam ST_RUN  = 2'b10;

  // ------------------------------------------------------------------
  // mask presence and run state
  // ------------------------------------------------------------------
  wire       mask_en;
  reg  [1:0] state_ff;
  reg  [1:0] nxt_state;
  wire       run;

  // mask port is honoured only in the settings that carry it
  assign mask_en = ((MEM_TYPE == `DCPW_MEM_DDR3) &&
                    (DM_MODE == `DCPW_DM_MASK)) ||
                   ((MEM_TYPE == `DCPW_MEM_DDR4) &&
                    ((DM_MODE == `DCPW_DM_MASK) ||
                     (DM_MODE == `DCPW_DM_MASK_RDINV)));

  assign run = state_ff[1];

  // wait for calibration, fall back if it drops
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_WAIT: begin
        if (calibration_complete_i) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!calibration_complete_i) begin
          nxt_state = ST_WAIT;
        end
      end
      default: begin
        nxt_state = ST_WAIT;
      end
    endcase
  end

  // state register
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= ST_WAIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ------------------------------------------------------------------
  // rank control split per channel
  // ------------------------------------------------------------------
  wire [CKE_CH-1:0] cke_ch0_src;
  wire [CKE_CH-1:0] cke_ch1_src;

  // shared clock enable drives both channels from one field
  generate
    if (CKE_SHARED != 0) begin : g_cke_shared
      assign cke_ch0_src = cmd_clock_enable_in_i;
      assign cke_ch1_src = cmd_clock_enable_in_i;
    end else begin : g_cke_split
      assign cke_ch0_src = cmd_clock_enable_in_i[CKE_CH-1:0];
      assign cke_ch1_src = cmd_clock_enable_in_i[CKE_BUS-1:CKE_CH];
    end
  endgenerate

  // halves hold {rank1, rank0} bytes; chip select idles high
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ch0_cke_o      <= {CKE_CH{1'b0}};
      ch1_cke_o      <= {CKE_CH{1'b0}};
      ch0_cs_b_o     <= {CS_CH{1'b1}};
      ch1_cs_b_o     <= {CS_CH{1'b1}};
      ch0_odt_o      <= {ODT_CH{1'b0}};
      ch1_odt_o      <= {ODT_CH{1'b0}};
      logical_rank_o <= {LR_BUS{1'b0}};
    end else begin
      ch0_cke_o      <= cke_ch0_src;
      ch1_cke_o      <= cke_ch1_src;
      ch0_cs_b_o     <= cmd_chip_select_in_b_i[CS_CH-1:0];
      ch1_cs_b_o     <= cmd_chip_select_in_b_i[CS_BUS-1:CS_CH];
      ch0_odt_o      <= cmd_termination_in_i[ODT_CH-1:0];
      ch1_odt_o      <= cmd_termination_in_i[ODT_BUS-1:ODT_CH];
      logical_rank_o <= cmd_logical_rank_in_i;
    end
  end

  // ------------------------------------------------------------------
  // command slots: a slot is busy when any chip select bit of its pairs is low
  // ------------------------------------------------------------------
  wire [2*`DCPW_SLOTS-1:0] slot_busy;

  genvar gs;
  genvar gp;
  generate
    for (gs = 0; gs < 2 * `DCPW_SLOTS; gs = gs + 1) begin : g_slot
      wire [`DCPW_CS_PINS-1:0] pin_low;
      for (gp = 0; gp < `DCPW_CS_PINS; gp = gp + 1) begin : g_pin
        // pair k of each pin byte is dram clock k, lowest first
        assign pin_low[gp] = ~&cmd_chip_select_in_b_i[
          (gs / `DCPW_SLOTS) * CS_CH + gp * `DCPW_BITS_PER_PIN +
          (gs % `DCPW_SLOTS) * `DCPW_SLOT_W +: `DCPW_SLOT_W];
      end
      assign slot_busy[gs] = |pin_low;
    end
  endgenerate

  // slot status {ch1 slots, ch0 slots}
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_slots_o <= {(2*`DCPW_SLOTS){1'b0}};
    end else begin
      cmd_slots_o <= slot_busy;
    end
  end

  // ------------------------------------------------------------------
  // latency latch and reserved input check
  // ------------------------------------------------------------------
  // latency is taken while waiting so it never moves under traffic
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      write_latency_out_o  <= `DCPW_LAT_RST;
      reserved_tag_fault_o <= 1'b0;
    end else begin
      if (!run) begin
        write_latency_out_o <= write_latency_cfg_i;
      end
      // the reserved tag is expected low; flag any other value
      reserved_tag_fault_o <= |reserved_buffer_tag_in_i;
    end
  end

  // ------------------------------------------------------------------
  // write request and capture per channel
  // ------------------------------------------------------------------
  wire [1:0]               push;
  wire [`DCPW_DLY_W-1:0]   delay;
  wire [DQ_BUS-1:0]        wdata_all;
  wire [DM_BUS-1:0]        wmask_all;
  reg  [`DCPW_CNT_W-1:0]   pend_cnt_ff [0:1];
  integer                  ci;

  // commands before calibration never make a request
  assign push  = wr_cmd_i & {2{run}};
  assign delay = write_latency_out_o[`DCPW_DLY_MSB:`DCPW_DLY_LSB];

  genvar gc;
  generate
    for (gc = 0; gc < 2; gc = gc + 1) begin : g_ch
      // bit gc of request, tag field gc, data half gc
      dcpw_wr_pipe u_pipe (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .flush_i (~run),
        .delay_i (delay),
        .push_i  (push[gc]),
        .tag_i   (wr_cmd_tag_i[gc*`DCPW_TAG_W +: `DCPW_TAG_W]),
        .req_o   (write_payload_request_o[gc]),
        .tag_o   (write_buffer_tag_out_o[
                    gc*`DCPW_TAG_W +: `DCPW_TAG_W])
      );

      dcpw_wr_capture #(
        .DW (DQ_CH),
        .MW (DM_CH)
      ) u_cap (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .req_i     (write_payload_request_o[gc]),
        .mask_en_i (mask_en),
        .data_i    (write_payload_in_i[gc*DQ_CH +: DQ_CH]),
        .mask_i    (write_byte_mask_in_i[gc*DM_CH +: DM_CH]),
        .data_o    (wdata_all[gc*DQ_CH +: DQ_CH]),
        .mask_o    (wmask_all[gc*DM_CH +: DM_CH]),
        .valid_o   (wdata_valid_o[gc])
      );
    end
  endgenerate

  // count writes between command and request, one process for both
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_cnt_ff[0] <= {`DCPW_CNT_W{1'b0}};
      pend_cnt_ff[1] <= {`DCPW_CNT_W{1'b0}};
    end else begin
      for (ci = 0; ci < 2; ci = ci + 1) begin
        if (!run) begin
          pend_cnt_ff[ci] <= {`DCPW_CNT_W{1'b0}};
        end else if (push[ci] && !write_payload_request_o[ci]) begin
          pend_cnt_ff[ci] <= pend_cnt_ff[ci] + 5'h01;
        end else if (!push[ci] && write_payload_request_o[ci] &&
                     (pend_cnt_ff[ci] != 5'h00)) begin
          pend_cnt_ff[ci] <= pend_cnt_ff[ci] - 5'h01;
        end
      end
    end
  end

  // captured bursts come straight from the capture registers
  assign ch0_wdata_o = wdata_all[DQ_CH-1:0];
  assign ch1_wdata_o = wdata_all[DQ_BUS-1:DQ_CH];
  assign ch0_wmask_o = wmask_all[DM_CH-1:0];
  assign ch1_wmask_o = wmask_all[DM_BUS-1:DM_CH];

  // pending flag per channel
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pending_o <= 2'h0;
    end else begin
      wr_pending_o <= {(pend_cnt_ff[1] != 5'h00),
                       (pend_cnt_ff[0] != 5'h00)};
    end
  end

endmodule
`default_nettype wire

// ==== dcpw_properties.sv ====
// checker for the two-channel phy port: command halves, request timing
// assumes default parameters of dcpw_top and a bind onto it
`timescale 1ns/1ps
`default_nettype none
module dcpw_props (
  // clock, reset and status
  input wire logic         clk_i,
  input wire logic         rst_b_i,
  input wire logic         calibration_complete_i,
  // controller side
  input wire logic [1:0]   wr_cmd_i,
  input wire logic [9:0]   wr_cmd_tag_i,
  input wire logic [5:0]   write_latency_cfg_i,
  input wire logic [31:0]  cmd_chip_select_in_b_i,
  input wire logic [255:0] write_payload_in_i,
  input wire logic [31:0]  write_byte_mask_in_i,
  // phy side
  input wire logic [15:0]  ch0_cs_b_o,
  input wire logic [15:0]  ch1_cs_b_o,
  input wire logic [1:0]   write_payload_request_o,
  input wire logic [9:0]   write_buffer_tag_out_o,
  input wire logic [5:0]   write_latency_out_o,
  input wire logic [127:0] ch0_wdata_o,
  input wire logic [127:0] ch1_wdata_o,
  input wire logic [15:0]  ch0_wmask_o,
  input wire logic [1:0]   wdata_valid_o
);
  // ------------------------------------------------------------
  // properties, one clock domain
  // ------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  cs_split_a: assert property ($past(rst_b_i) |->
    ch0_cs_b_o == $past(cmd_chip_select_in_b_i[15:0]) &&
    ch1_cs_b_o == $past(cmd_chip_select_in_b_i[31:16]))
    else $error("chip select halves wrong");
  req_ch0_a: assert property (
    wr_cmd_i[0] && write_latency_out_o[5:2] <= 4'h1 &&
    $past(calibration_complete_i) ##0 calibration_complete_i [*3] |->
    write_payload_request_o[0] &&
    write_buffer_tag_out_o[4:0] == $past(wr_cmd_tag_i[4:0], 2))
    else $error("channel 0 request late or tag wrong");
  req_ch1_a: assert property (
    wr_cmd_i[1] && write_latency_out_o[5:2] <= 4'h1 &&
    $past(calibration_complete_i) ##0 calibration_complete_i [*3] |->
    write_payload_request_o[1] &&
    write_buffer_tag_out_o[9:5] == $past(wr_cmd_tag_i[9:5], 2))
    else $error("channel 1 request late or tag wrong");
  idle_req_a: assert property (
    !calibration_complete_i [*3] |->
    write_payload_request_o == 2'b00)
    else $error("request while not calibrated");
  cap_ch0_a: assert property (
    write_payload_request_o[0] |-> ##2 wdata_valid_o[0] &&
    ch0_wdata_o == $past(write_payload_in_i[127:0]) &&
    ch0_wmask_o == $past(write_byte_mask_in_i[15:0]))
    else $error("channel 0 burst not taken next cycle");
  cap_ch1_a: assert property (
    write_payload_request_o[1] |-> ##2 wdata_valid_o[1] &&
    ch1_wdata_o == $past(write_payload_in_i[255:128]))
    else $error("channel 1 burst not taken next cycle");
  lat_latch_a: assert property (
    !calibration_complete_i ##1 !calibration_complete_i |=>
    write_latency_out_o == $past(write_latency_cfg_i))
    else $error("latency not latched while idle");
  lat_hold_a: assert property (
    calibration_complete_i && $past(calibration_complete_i) |=>
    $stable(write_latency_out_o))
    else $error("latency changed while running");
endmodule

bind dcpw_top dcpw_props dcpw_props_i (.clk_i, .rst_b_i,
  .calibration_complete_i, .wr_cmd_i, .wr_cmd_tag_i,
  .write_latency_cfg_i, .cmd_chip_select_in_b_i, .write_payload_in_i,
  .write_byte_mask_in_i, .ch0_cs_b_o, .ch1_cs_b_o,
  .write_payload_request_o, .write_buffer_tag_out_o,
  .write_latency_out_o, .ch0_wdata_o, .ch1_wdata_o, .ch0_wmask_o,
  .wdata_valid_o);
`default_nettype wire

// ==== dcpw_ctrl_model.sv ====
// controller model: answers every write request with its burst
// assumes requests are registers that change on the rising edge
`timescale 1ns/1ps
`default_nettype none
module dcpw_ctrl_model (
  // clock
  input  wire logic         clk_i,
  // request port of the phy
  input  wire logic [1:0]   req_i,
  input  wire logic [9:0]   tag_i,
  // write data towards the phy
  output var  logic [255:0] payload_o,
  output var  logic [31:0]  mask_o,
  output var  logic [9:0]   reserved_o
);
  logic [1:0] seen;
  logic [9:0] tags;
  // reserved tag input stays low
  assign reserved_o = 10'h000;
  initial begin
    payload_o = 256'h0;
    mask_o = 32'h0;
  end
  // burst one cycle after the request, scrambled otherwise
  always @(posedge clk_i) begin
    seen = req_i;
    tags = tag_i;
    #1;
    for (int c = 0; c < 2; c++) begin
      if (seen[c] === 1'b1) begin
        payload_o[c*128 +: 128] = {16{tags[c*5 +: 5], 3'h5}};
        mask_o[c*16 +: 16] = {4{tags[c*5 +: 4]}};
      end else begin
        payload_o[c*128 +: 128] = ~payload_o[c*128 +: 128];
        mask_o[c*16 +: 16] = ~mask_o[c*16 +: 16];
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// bench for the two-channel phy port with a controller model
// assumes default parameters: two pins per group, 32 dq lanes
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  num_errors++; $display("unexpected at %0t: %h vs %h", $time, a, b); \
  end end
module tb_top;
  typedef struct {
    logic [31:0] cs;
    logic [31:0] cke;
    logic [31:0] odt;
    logic [7:0]  lr;
    logic [7:0]  slots;
  } dcpw_row_t;
  dcpw_row_t rows [4] = '{
    '{32'hffff_ffff, 32'h0000_0000, 32'h0000_0000, 8'h00, 8'h00},
    '{32'hffff_fffe, 32'h1234_5678, 32'h8000_0001, 8'h5a, 8'h01},
    '{32'h7fff_ffff, 32'hdead_0f0f, 32'h00ff_ff00, 8'ha5, 8'h80},
    '{32'hfffb_dfff, 32'hffff_ffff, 32'hc3c3_3c3c, 8'hff, 8'h24}};
  logic         clk_i, rst_b_i, calibration_complete_i;
  logic [31:0]  cmd_clock_enable_in_i, cmd_chip_select_in_b_i;
  logic [31:0]  cmd_termination_in_i, write_byte_mask_in_i;
  logic [7:0]   cmd_logical_rank_in_i, logical_rank_o, cmd_slots_o;
  logic [1:0]   wr_cmd_i, write_payload_request_o;
  logic [1:0]   wr_pending_o, wdata_valid_o;
  logic [9:0]   wr_cmd_tag_i, reserved_buffer_tag_in_i;
  logic [9:0]   write_buffer_tag_out_o;
  logic [5:0]   write_latency_cfg_i, write_latency_out_o;
  logic [255:0] write_payload_in_i;
  logic [15:0]  ch0_cke_o, ch1_cke_o, ch0_cs_b_o, ch1_cs_b_o;
  logic [15:0]  ch0_odt_o, ch1_odt_o, ch0_wmask_o, ch1_wmask_o;
  logic [127:0] ch0_wdata_o, ch1_wdata_o;
  logic         reserved_tag_fault_o;
  logic [4:0]   tq [2][$];
  logic [4:0]   dq [2][$];
  logic [4:0]   t;
  int           num_errors = 0;
  int           samples_checked = 0;
  int           cycles = 0;

  dcpw_top dcpw_top_i (.clk_i, .rst_b_i, .calibration_complete_i,
    .cmd_clock_enable_in_i, .cmd_chip_select_in_b_i,
    .cmd_termination_in_i, .cmd_logical_rank_in_i, .wr_cmd_i,
    .wr_cmd_tag_i, .write_latency_cfg_i, .write_payload_in_i,
    .write_byte_mask_in_i, .reserved_buffer_tag_in_i, .ch0_cke_o,
    .ch1_cke_o, .ch0_cs_b_o, .ch1_cs_b_o, .ch0_odt_o, .ch1_odt_o,
    .logical_rank_o, .cmd_slots_o, .write_payload_request_o,
    .write_buffer_tag_out_o, .write_latency_out_o, .wr_pending_o,
    .reserved_tag_fault_o, .ch0_wdata_o, .ch1_wdata_o, .ch0_wmask_o,
    .ch1_wmask_o, .wdata_valid_o);
  dcpw_ctrl_model dcpw_ctrl_model_i (.clk_i,
    .req_i(write_payload_request_o), .tag_i(write_buffer_tag_out_o),
    .payload_o(write_payload_in_i), .mask_o(write_byte_mask_in_i),
    .reserved_o(reserved_buffer_tag_in_i));

  // ------------------------------------------------------------
  // clock, timeout and helpers
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task print_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task tick;
    @(posedge clk_i);
    #1;
  endtask
  // command taken at one edge; the caller lowers it after the last
  task wr(input logic [1:0] ch, input logic [9:0] tag);
    wr_cmd_i = ch;
    wr_cmd_tag_i = tag;
    for (int c = 0; c < 2; c++)
      if (ch[c]) tq[c].push_back(tag[c*5 +: 5]);
    tick();
  endtask
  // timeout, and tag and burst checks on every request
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 2000) begin
      num_errors++;
      print_verdict();
    end
    for (int c = 0; c < 2; c++) begin
      if (write_payload_request_o[c] === 1'b1) begin
        if (tq[c].size() == 0) `CHK(1'b1, 1'b0)
        else begin
          `CHK(write_buffer_tag_out_o[c*5 +: 5], tq[c][0])
          dq[c].push_back(tq[c].pop_front());
        end
      end
      if (wdata_valid_o[c] === 1'b1) begin
        t = dq[c].pop_front();
        `CHK(c ? ch1_wdata_o : ch0_wdata_o, {16{t, 3'h5}})
        `CHK(c ? ch1_wmask_o : ch0_wmask_o, {4{t[3:0]}})
      end
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_b_i = 1'b0;
    calibration_complete_i = 1'b0;
    cmd_clock_enable_in_i = 32'h0;
    cmd_chip_select_in_b_i = 32'hffff_ffff;
    cmd_termination_in_i = 32'h0;
    cmd_logical_rank_in_i = 8'h0;
    wr_cmd_i = 2'b00;
    wr_cmd_tag_i = 10'h000;
    write_latency_cfg_i = 6'h02;
    repeat (20) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    `CHK({ch1_cs_b_o, ch0_cs_b_o}, 32'hffff_ffff)
    `CHK(write_payload_request_o, 2'b00)
    wr(2'b11, 10'h3ff);
    wr_cmd_i = 2'b00;
    tq[0].delete();
    tq[1].delete();
    repeat (5) tick();
    `CHK(wr_pending_o, 2'b00)
    `CHK(write_latency_out_o, 6'h02)
    calibration_complete_i = 1'b1;
    tick();
    foreach (rows[i]) begin
      cmd_chip_select_in_b_i = rows[i].cs;
      cmd_clock_enable_in_i = rows[i].cke;
      cmd_termination_in_i = rows[i].odt;
      cmd_logical_rank_in_i = rows[i].lr;
      tick();
      `CHK({ch1_cs_b_o, ch0_cs_b_o}, rows[i].cs)
      `CHK({ch1_cke_o, ch0_cke_o}, rows[i].cke)
      `CHK({ch1_odt_o, ch0_odt_o}, rows[i].odt)
      `CHK(logical_rank_o, rows[i].lr)
      `CHK(cmd_slots_o, rows[i].slots)
    end
    // zero delay field acts as one: request one edge after command edge
    wr(2'b01, 10'h00a);
    wr_cmd_i = 2'b00;
    `CHK(write_payload_request_o, 2'b00)
    tick();
    `CHK(write_payload_request_o, 2'b01)
    tick();
    `CHK(write_payload_request_o, 2'b00)
    // back-to-back and interleaved commands keep their order
    for (int i = 0; i < 3; i++)
      wr(2'b11, 10'h0e1 + 10'h021 * i[9:0]);
    wr(2'b10, 10'h2a0);
    wr(2'b01, 10'h01f);
    wr_cmd_i = 2'b00;
    repeat (6) tick();
    `CHK(tq[0].size() + tq[1].size(), 0)
    `CHK(dq[0].size() + dq[1].size(), 0)
    // calibration drop relatches the latency while idle
    calibration_complete_i = 1'b0;
    write_latency_cfg_i = 6'h0f;
    repeat (4) tick();
    `CHK(wr_pending_o, 2'b00)
    `CHK(write_latency_out_o, 6'h0f)
    calibration_complete_i = 1'b1;
    tick();
    // delay field of three, latency frozen while running
    write_latency_cfg_i = 6'h04;
    wr(2'b10, 10'h2a0);
    wr_cmd_i = 2'b00;
    tick();
    `CHK(wr_pending_o, 2'b10)
    tick();
    `CHK(write_payload_request_o, 2'b00)
    tick();
    `CHK(write_payload_request_o, 2'b10)
    `CHK(write_latency_out_o, 6'h0f)
    // calibration drop loses the write still in the delay line
    wr(2'b01, 10'h015);
    wr_cmd_i = 2'b00;
    calibration_complete_i = 1'b0;
    tq[0].delete();
    repeat (4) tick();
    `CHK(wr_pending_o, 2'b00)
    `CHK(write_payload_request_o, 2'b00)
    `CHK(reserved_tag_fault_o, 1'b0)
    // second reset while idle after the calibration drop, then release while not calibrated
    rst_b_i = 1'b0;
    #1;
    `CHK({ch1_cs_b_o, ch0_cs_b_o}, 32'hffff_ffff)
    `CHK(write_payload_request_o, 2'b00)
    `CHK(write_latency_out_o, 6'h00)
    tick();
    rst_b_i = 1'b1;
    tick();
    `CHK(write_payload_request_o, 2'b00)
    `CHK(write_latency_out_o, 6'h04)
    print_verdict();
  end
endmodule
`default_nettype wire
